// ### src/pac_pkg.sv
// Shared constants and types of the PCI arbitration and error block.
package pac_pkg;

   // ------------------------------------------------------------------
   // Configuration register offsets (byte addresses)
   // ------------------------------------------------------------------
   localparam logic [7:0] OFS_CONFIG_LO = 8'h50;
   localparam logic [7:0] OFS_CONFIG_HI = 8'h51;
   localparam logic [7:0] OFS_MTT       = 8'h70;
   localparam logic [7:0] OFS_MSTS      = 8'h82;
   localparam logic [7:0] OFS_ECMD      = 8'h90;
   localparam logic [7:0] OFS_ESTS      = 8'h92;

   // ------------------------------------------------------------------
   // Reset values and writable-bit masks
   // ------------------------------------------------------------------
   localparam logic [15:0] RST_CONFIG   = 16'h1400;
   localparam logic [7:0]  RST_MTT      = 8'h20;
   localparam logic [7:0]  RST_MSTS     = 8'h00;
   localparam logic [7:0]  RST_ECMD     = 8'h00;
   localparam logic [7:0]  RST_ESTS     = 8'h00;
   localparam logic [15:0] WMASK_CONFIG = 16'h2302;
   localparam logic [7:0]  WMASK_MTT    = 8'hf8;
   localparam logic [7:0]  WMASK_MSTS   = 8'hff;
   localparam logic [7:0]  WMASK_ECMD   = 8'h04;
   localparam logic [7:0]  WMASK_ESTS   = 8'h04;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int CFG_PREFETCH_BIT = 13;
   localparam int CFG_HP_BIT       = 9;
   localparam int CFG_HOLE_BIT     = 8;
   localparam int CFG_RETRY_BIT    = 1;
   localparam int MSTS_INT_BIT     = 7;
   localparam int MSTS_LAN_BIT     = 6;
   localparam int ERR_RTA_BIT      = 2;

   // ------------------------------------------------------------------
   // Agents, address hole and timing
   // ------------------------------------------------------------------
   localparam int N_EXT       = 6;
   localparam int N_AGENT     = 8;
   localparam int AGENT_LAN   = 6;
   localparam int AGENT_INT   = 7;
   localparam logic [31:0] HOLE_BASE  = 32'h00f00000;
   localparam logic [31:0] HOLE_LIMIT = 32'h01000000;
   localparam int SYS_PERIOD_NS = 10;
   localparam int PCI_PERIOD_NS = 30;
   localparam logic [1:0] PCI_DIV =
      2'(PCI_PERIOD_NS / SYS_PERIOD_NS);
   localparam logic [3:0] RETRY_CLOCKS = 4'hc;

   typedef logic [N_AGENT-1:0] pac_agents_t;

endpackage

// ### src/pac_arbiter.sv
// Round-robin PCI arbiter with high-priority pair and time slice.
`timescale 1ns/1ps
module pac_arbiter (
   input  wire logic                clk_sys,
   input  wire logic                rst,
   input  wire logic                tick,
   input  wire pac_pkg::pac_agents_t req,
   input  wire logic                hp_en,
   input  wire logic [7:0]          slice,
   output      pac_pkg::pac_agents_t gnt_n
);
   import pac_pkg::*;

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      pac_agents_t gnt_n;
      logic        owned;
      logic [2:0]  owner;
      logic [7:0]  slice_cnt;
   } pac_arb_state_t;

   pac_arb_state_t st;
   pac_arb_state_t next_st;

   // Returns {valid, index}; pair zero first when the priority mode is on.
   function automatic logic [3:0] pick(input pac_agents_t r,
                                       input logic [2:0]  last,
                                       input logic        hp);
      logic [3:0] res;
      logic [2:0] idx;
      res = 4'h0;
      if (hp && r[0]) begin
         res = 4'h8;
      end else begin
         for (int i = N_AGENT; i >= 1; i--) begin
            idx = 3'(last + 3'(i));
            if (r[idx]) begin
               res = {1'b1, idx};
            end
         end
      end
      return res;
   endfunction

   assign gnt_n = st.gnt_n;

   // ------------------------------------------------------------------
   // Arbitration
   // ------------------------------------------------------------------
   always_comb begin
      logic [3:0]  win;
      pac_agents_t others;
      next_st = st;
      others  = req;
      others[st.owner] = 1'b0;
      win = pick(st.owned ? others : req, st.owner, hp_en);
      if (tick) begin
         if (!st.owned || !req[st.owner]) begin
            next_st.owned = win[3];
            next_st.owner = win[2:0];
            next_st.gnt_n = '1;
            if (win[3]) begin
               next_st.gnt_n[win[2:0]] = 1'b0;
            end
            next_st.slice_cnt = slice;
         end else if (slice != 8'h00) begin
            if (st.slice_cnt > 8'h01) begin
               next_st.slice_cnt = st.slice_cnt - 8'h01;
            end else if (win[3]) begin
               next_st.owner     = win[2:0];
               next_st.gnt_n     = '1;
               next_st.gnt_n[win[2:0]] = 1'b0;
               next_st.slice_cnt = slice;
            end
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st <= '{gnt_n: '1, owned: 1'b0, owner: 3'h0, slice_cnt: 8'h00};
      end else begin
         st <= next_st;
      end
   end

endmodule

// ### src/pac_bridge.sv
// Bridge configuration, arbitration policy and error reporting logic.
//
// Behaviour
// - Flush on: deliver demand data after write.
// - Pair zero wins when priority enabled.
// - Hole enable maps out 15 MB to 16 MB.
// - Retry enabled: retry memory cycle after 12.
// - Retry disabled: wait states, never retry.
// - Time slice expiry grants another requester.
// - Slice field bits 7:3, eight-clock units.
// - Timer resets to 20h, 32 clocks.
// - Timer value zero disables slicing.
// - Short slice expires early, then re-arbitrates.
// - Internal DMA or bus request sets bit 7.
// - Network controller request sets bit 6.
// - External request n sets status bit n.
// - Status bits stay until one is written.
// - Target abort sets bit 2, write-one clears.
// - System error needs enable, command, flag.
// - System error raised as NMI or SMI.
// - Defined reset values of all registers.
`timescale 1ns/1ps
module pac_bridge (
   input  wire logic               clk_sys,
   input  wire logic               rst,
   // Configuration port
   input  wire logic [7:0]         cfg_addr,
   input  wire logic [7:0]         cfg_wdata,
   input  wire logic               cfg_we,
   input  wire logic               cfg_re,
   output logic      [7:0]         cfg_rdata,
   output logic                    cfg_rvalid,
   // Bus requests and grants
   input  wire logic [pac_pkg::N_EXT-1:0] ext_req_n,
   input  wire logic               lan_req,
   input  wire logic               int_req,
   output logic [pac_pkg::N_EXT-1:0] ext_gnt_n,
   output logic                    lan_gnt_n,
   output logic                    int_gnt_n,
   // PCI-to-memory cycles
   input  wire logic               mem_cycle_start,
   input  wire logic               mem_cycle_done,
   input  wire logic [31:0]        mem_addr,
   output logic                    mem_retry,
   output logic                    mem_wait,
   output logic                    mem_in_hole,
   // Delayed transactions
   input  wire logic               dt_start,
   input  wire logic               cpu_write,
   input  wire logic               dt_data_ready,
   output logic                    dt_deliver,
   // Errors
   input  wire logic               target_abort,
   input  wire logic               system_error_enable,
   input  wire logic               serr_to_smi,
   output logic                    serr_active,
   output logic                    nmi_req,
   output logic                    smi_req
);
   import pac_pkg::*;

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [15:0] bridge_config;
      logic [7:0]  multi_transaction_timer;
      logic [7:0]  master_request_status;
      logic [7:0]  error_command;
      logic [7:0]  error_status;
      logic [7:0]  rdata;
      logic        rvalid;
      logic [1:0]  div_cnt;
      logic        tick;
      logic        cyc_active;
      logic [3:0]  retry_cnt;
      logic        retry;
      logic        wait_st;
      logic        in_hole;
      logic        write_seen;
      logic        deliver;
      logic        serr;
      logic        nmi;
      logic        smi;
   } pac_state_t;

   pac_state_t  st;
   pac_state_t  next_st;
   pac_agents_t agent_req;
   pac_agents_t agent_gnt_n;

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   // Only bits in the mask change, so reserved bits keep their reset value.
   function automatic logic [7:0] rw_merge(input logic [7:0] old,
                                           input logic [7:0] data,
                                           input logic [7:0] mask);
      return (old & ~mask) | (data & mask);
   endfunction

   // Write-one-to-clear with a set that wins over a clear in one cycle.
   function automatic logic [7:0] w1c_merge(input logic [7:0] old,
                                            input logic [7:0] data,
                                            input logic [7:0] mask,
                                            input logic       wr,
                                            input logic [7:0] set);
      logic [7:0] clr;
      clr = wr ? (data & mask) : 8'h00;
      return (old & ~clr) | (set & mask);
   endfunction

   function automatic logic [7:0] read_reg(input pac_state_t s,
                                           input logic [7:0] a);
      logic [7:0] v;
      v = 8'h00;
      unique case (a)
         OFS_CONFIG_LO: v = s.bridge_config[7:0];
         OFS_CONFIG_HI: v = s.bridge_config[15:8];
         OFS_MTT:       v = s.multi_transaction_timer;
         OFS_MSTS:      v = s.master_request_status;
         OFS_ECMD:      v = s.error_command;
         OFS_ESTS:      v = s.error_status;
         default:       v = 8'h00;
      endcase
      return v;
   endfunction

   // ------------------------------------------------------------------
   // Arbiter
   // ------------------------------------------------------------------
   always_comb begin
      agent_req = '0;
      agent_req[N_EXT-1:0] = ~ext_req_n;
      agent_req[AGENT_LAN] = lan_req;
      agent_req[AGENT_INT] = int_req;
   end

   // The slice field is already scaled by eight, so the byte value is the
   // slice length in PCI clocks; masking bits 2:0 keeps that exact.
   pac_arbiter u_arbiter (
      .clk_sys (clk_sys),
      .rst     (rst),
      .tick    (st.tick),
      .req     (agent_req),
      .hp_en   (st.bridge_config[CFG_HP_BIT]),
      .slice   (st.multi_transaction_timer & WMASK_MTT),
      .gnt_n   (agent_gnt_n)
   );

   assign ext_gnt_n   = agent_gnt_n[N_EXT-1:0];
   assign lan_gnt_n   = agent_gnt_n[AGENT_LAN];
   assign int_gnt_n   = agent_gnt_n[AGENT_INT];
   assign cfg_rdata   = st.rdata;
   assign cfg_rvalid  = st.rvalid;
   assign mem_retry   = st.retry;
   assign mem_wait    = st.wait_st;
   assign mem_in_hole = st.in_hole;
   assign dt_deliver  = st.deliver;
   assign serr_active = st.serr;
   assign nmi_req     = st.nmi;
   assign smi_req     = st.smi;

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      logic [7:0] req_set;
      logic [7:0] err_set;
      logic       sys_err;
      next_st = st;

      // PCI clock enable derived from the system clock.
      next_st.tick = 1'b0;
      if (st.div_cnt == PCI_DIV - 2'h1) begin
         next_st.div_cnt = 2'h0;
         next_st.tick    = 1'b1;
      end else begin
         next_st.div_cnt = st.div_cnt + 2'h1;
      end

      // Register reads answer one cycle later.
      next_st.rvalid = cfg_re;
      if (cfg_re) begin
         next_st.rdata = read_reg(st, cfg_addr);
      end

      // Control register writes.
      if (cfg_we) begin
         unique case (cfg_addr)
            OFS_CONFIG_LO: next_st.bridge_config[7:0] =
               rw_merge(st.bridge_config[7:0], cfg_wdata,
                        WMASK_CONFIG[7:0]);
            OFS_CONFIG_HI: next_st.bridge_config[15:8] =
               rw_merge(st.bridge_config[15:8], cfg_wdata,
                        WMASK_CONFIG[15:8]);
            OFS_MTT: next_st.multi_transaction_timer =
               rw_merge(st.multi_transaction_timer, cfg_wdata,
                        WMASK_MTT);
            OFS_ECMD: next_st.error_command =
               rw_merge(st.error_command, cfg_wdata, WMASK_ECMD);
            default: begin
            end
         endcase
      end

      // Sticky request status.
      req_set = 8'h00;
      req_set[N_EXT-1:0]   = ~ext_req_n;
      req_set[MSTS_LAN_BIT] = lan_req;
      req_set[MSTS_INT_BIT] = int_req;
      next_st.master_request_status =
         w1c_merge(st.master_request_status, cfg_wdata, WMASK_MSTS,
                   cfg_we && cfg_addr == OFS_MSTS, req_set);

      // Received target abort status.
      err_set = 8'h00;
      err_set[ERR_RTA_BIT] = target_abort;
      next_st.error_status =
         w1c_merge(st.error_status, cfg_wdata, WMASK_ESTS,
                   cfg_we && cfg_addr == OFS_ESTS, err_set);

      // System error: all three conditions must hold.
      sys_err = st.error_command[ERR_RTA_BIT] && system_error_enable &&
                st.error_status[ERR_RTA_BIT];
      next_st.serr = sys_err;
      next_st.nmi  = sys_err && !serr_to_smi;
      next_st.smi  = sys_err && serr_to_smi;

      // Memory hole decode.
      next_st.in_hole = st.bridge_config[CFG_HOLE_BIT] &&
                        mem_addr >= HOLE_BASE &&
                        mem_addr < HOLE_LIMIT;

      // PCI-to-memory cycle timing.
      next_st.retry = 1'b0;
      if (mem_cycle_start) begin
         next_st.cyc_active = 1'b1;
         next_st.retry_cnt  = 4'h0;
      end else if (st.cyc_active) begin
         if (mem_cycle_done) begin
            next_st.cyc_active = 1'b0;
         end else if (st.tick) begin
            if (st.bridge_config[CFG_RETRY_BIT] &&
                st.retry_cnt == RETRY_CLOCKS - 4'h1) begin
               next_st.retry      = 1'b1;
               next_st.cyc_active = 1'b0;
            end else if (st.retry_cnt != RETRY_CLOCKS - 4'h1) begin
               next_st.retry_cnt = st.retry_cnt + 4'h1;
            end
         end
      end
      // Without retry the cycle simply waits until it completes.
      next_st.wait_st = next_st.cyc_active;

      // Delayed transaction delivery.
      if (dt_start) begin
         next_st.write_seen = 1'b0;
      end else if (cpu_write) begin
         next_st.write_seen = 1'b1;
      end
      next_st.deliver = dt_data_ready &&
                        (!st.bridge_config[CFG_PREFETCH_BIT] ||
                         st.write_seen);
   end

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st <= '0;
         st.bridge_config           <= RST_CONFIG;
         st.multi_transaction_timer <= RST_MTT;
         st.master_request_status   <= RST_MSTS;
         st.error_command           <= RST_ECMD;
         st.error_status            <= RST_ESTS;
      end else begin
         st <= next_st;
      end
   end

endmodule

// ### bench/pac_masters.sv
// Behavioural model of the six external bus masters.
`timescale 1ns/1ps
module pac_masters #(
   parameter int REL_DLY = 2
) (
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic [5:0] want,
   input  wire logic [5:0] gnt_n,
   output logic      [5:0] ext_req_n
);
   int hold [6];
   // A granted master keeps requesting a few clocks after it is done, as a
   // slow device finishing its last data phase would.
   always_ff @(posedge clk_sys or posedge rst) begin
      foreach (hold[i]) begin
         if (rst) begin
            hold[i] <= 0;
         end else if (want[i]) begin
            hold[i] <= REL_DLY;
         end else if (gnt_n[i]) begin
            hold[i] <= 0;
         end else if (hold[i] > 0) begin
            hold[i] <= hold[i] - 1;
         end
      end
   end
   // A released request line floats up to its pull-up level.
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         ext_req_n[i] = !(want[i] || hold[i] > 0);
      end
   end
endmodule

// ### bench/pac_bridge_properties.sv
// Port-level assertions for the bridge block.
`timescale 1ns/1ps
module pac_bridge_props (
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic [7:0]  cfg_addr,
   input wire logic [7:0]  cfg_wdata,
   input wire logic        cfg_we,
   input wire logic        cfg_re,
   input wire logic        cfg_rvalid,
   input wire logic [5:0]  ext_gnt_n,
   input wire logic        lan_gnt_n,
   input wire logic        int_gnt_n,
   input wire logic        mem_cycle_start,
   input wire logic [31:0] mem_addr,
   input wire logic        mem_retry,
   input wire logic        mem_wait,
   input wire logic        mem_in_hole,
   input wire logic        dt_data_ready,
   input wire logic        dt_deliver,
   input wire logic        target_abort,
   input wire logic        system_error_enable,
   input wire logic        serr_active,
   input wire logic        nmi_req,
   input wire logic        smi_req
);
   import pac_pkg::*;
   logic       retry_en;
   logic       hole_en;
   logic       rta_en;
   logic [7:0] busy;
   logic       in_rng;
   assign in_rng = mem_addr >= HOLE_BASE && mem_addr < HOLE_LIMIT;
   // Enable bits are shadowed from the write strobes, never from the design.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         retry_en <= 1'b0;
         hole_en <= 1'b0;
         rta_en <= 1'b0;
         busy <= 8'h00;
      end else begin
         if (cfg_we && cfg_addr == OFS_CONFIG_LO) begin
            retry_en <= cfg_wdata[CFG_RETRY_BIT];
         end
         if (cfg_we && cfg_addr == OFS_CONFIG_HI) begin
            hole_en <= cfg_wdata[CFG_HOLE_BIT-8];
         end
         if (cfg_we && cfg_addr == OFS_ECMD) begin
            rta_en <= cfg_wdata[ERR_RTA_BIT];
         end
         if (mem_cycle_start) begin
            busy <= 8'h00;
         end else if (mem_wait && busy != 8'hff) begin
            busy <= busy + 8'h01;
         end
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   read_answer_a: assert property (cfg_re |=> cfg_rvalid)
      else $error("read strobe not answered");
   no_stray_a: assert property (!cfg_re |=> !cfg_rvalid)
      else $error("read valid without strobe");
   hole_window_a: assert property (!$past(rst) |->
      mem_in_hole == $past(hole_en && in_rng))
      else $error("hole flag wrong");
   retry_gate_a: assert property (mem_retry |-> retry_en)
      else $error("retry while retry disabled");
   retry_time_a: assert property (mem_retry |->
      !mem_wait && busy >= 8'h21 && busy <= 8'h26)
      else $error("retry at wrong time");
   serr_cause_a: assert property (target_abort && rta_en
      && system_error_enable ##1 system_error_enable |=> serr_active)
      else $error("target abort not reported");
   serr_gate_a: assert property (!system_error_enable || !rta_en
      |=> !serr_active)
      else $error("system error while disabled");
   serr_route_a: assert property (serr_active == (nmi_req | smi_req)
      && !(nmi_req && smi_req))
      else $error("system error routing wrong");
   deliver_ready_a: assert property (dt_deliver |-> $past(dt_data_ready))
      else $error("data delivered before ready");
   one_owner_a: assert property (
      $onehot0(~{int_gnt_n, lan_gnt_n, ext_gnt_n}))
      else $error("more than one grant");
   cover property (mem_retry);
   cover property (serr_active);
   cover property (mem_in_hole);
   cover property (dt_deliver);
endmodule
bind pac_bridge pac_bridge_props chk (.clk_sys, .rst, .cfg_addr, .cfg_wdata,
   .cfg_we, .cfg_re, .cfg_rvalid, .ext_gnt_n, .lan_gnt_n, .int_gnt_n,
   .mem_cycle_start, .mem_addr, .mem_retry, .mem_wait, .mem_in_hole,
   .dt_data_ready, .dt_deliver, .target_abort, .system_error_enable,
   .serr_active, .nmi_req, .smi_req);

// ### bench/pac_bridge_bench.sv
// Directed bench for the bridge block with a model of the bus masters.
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin \
   n_fail++; $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp); \
   end end
module pac_bridge_bench;
   import pac_pkg::*;
   logic        clk_sys = 1'b0, rst = 1'b1, seen;
   logic [7:0]  cfg_addr = 8'h00, cfg_wdata = 8'h00, cfg_rdata;
   logic        cfg_we = 1'b0, cfg_re = 1'b0, cfg_rvalid;
   logic [5:0]  ext_req_n, ext_gnt_n, want = 6'h00, g;
   logic        lan_req = 1'b0, int_req = 1'b0, lan_gnt_n, int_gnt_n;
   logic        mem_cycle_start = 1'b0, mem_cycle_done = 1'b0;
   logic        mem_retry, mem_wait, mem_in_hole, dt_deliver;
   logic [31:0] mem_addr = 32'h0;
   logic        dt_start = 1'b0, cpu_write = 1'b0, dt_data_ready = 1'b0;
   logic        target_abort = 1'b0, system_error_enable = 1'b0;
   logic        serr_to_smi = 1'b0, serr_active, nmi_req, smi_req;
   logic [31:0] hole_addr [4] = '{32'h00efffff, 32'h00f00000,
                                  32'h00ffffff, 32'h01000000};
   int          n_fail = 0, n_compared = 0, len;
   always #5 clk_sys = ~clk_sys;
   pac_bridge dut (.clk_sys, .rst, .cfg_addr, .cfg_wdata, .cfg_we, .cfg_re,
      .cfg_rdata, .cfg_rvalid, .ext_req_n, .lan_req, .int_req, .ext_gnt_n,
      .lan_gnt_n, .int_gnt_n, .mem_cycle_start, .mem_cycle_done, .mem_addr,
      .mem_retry, .mem_wait, .mem_in_hole, .dt_start, .cpu_write,
      .dt_data_ready, .dt_deliver, .target_abort, .system_error_enable,
      .serr_to_smi, .serr_active, .nmi_req, .smi_req);
   pac_masters #(.REL_DLY(2)) masters (.clk_sys, .rst, .want,
      .gnt_n(ext_gnt_n), .ext_req_n);
   task automatic stop_test();
      $display("Compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic hang();
      n_fail++;
      $display("Wait limit reached at %0t", $time);
      stop_test();
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic pulse(ref logic s);
      tick(1);
      s = 1'b1;
      tick(1);
      s = 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      tick(1);
      cfg_addr = a;
      cfg_wdata = d;
      cfg_we = 1'b1;
      tick(1);
      cfg_we = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      int i;
      tick(1);
      cfg_addr = a;
      cfg_re = 1'b1;
      tick(1);
      cfg_re = 1'b0;
      for (i = 0; i < 4 && cfg_rvalid !== 1'b1; i++) tick(1);
      if (i == 4) hang();
      `CHK(cfg_rdata, e)
   endtask
   task automatic wait_gnt();
      int i;
      for (i = 0; i < 90 && ext_gnt_n === 6'h3f; i++) tick(1);
      if (i == 90) hang();
      g = ~ext_gnt_n;
   endtask
   task automatic wait_idle();
      int i;
      want = 6'h00;
      for (i = 0; i < 90 && {ext_gnt_n, lan_gnt_n, int_gnt_n} !== 8'hff;
           i++) tick(1);
      if (i == 90) hang();
   endtask
   task automatic hold(input int lim);
      logic [5:0] h;
      h = ext_gnt_n;
      for (len = 0; len < lim && ext_gnt_n === h; len++) tick(1);
   endtask
   // Lets the current slice run out, then measures the next one whole.
   task automatic slice(input int lo, input int hi);
      hold(300);
      if (len == 300) hang();
      wait_gnt();
      hold(300);
      `CHK(len >= lo && len <= hi, 1'b1)
   endtask
   initial begin
      tick(5);
      rst = 1'b0;
      rd(OFS_CONFIG_LO, 8'h00);
      rd(OFS_CONFIG_HI, 8'h14);
      rd(OFS_MTT, 8'h20);
      rd(OFS_MSTS, 8'h00);
      rd(OFS_ECMD, 8'h00);
      rd(OFS_ESTS, 8'h00);
      wr(OFS_CONFIG_LO, 8'hff);
      rd(OFS_CONFIG_LO, 8'h02);
      wr(OFS_CONFIG_HI, 8'hff);
      rd(OFS_CONFIG_HI, 8'h37);
      wr(OFS_ESTS, 8'hfb);
      rd(OFS_ESTS, 8'h00);
      wr(8'h60, 8'hff);
      rd(8'h60, 8'h00);
      wr(OFS_CONFIG_HI, 8'h20);
      want = 6'h06;
      wait_gnt();
      slice(90, 99);
      wr(OFS_MTT, 8'h0f);
      rd(OFS_MTT, 8'h08);
      slice(18, 27);
      wr(OFS_MTT, 8'h00);
      hold(300);
      wait_gnt();
      hold(200);
      `CHK(len, 200)
      wr(OFS_MTT, 8'h18);
      wait_idle();
      wr(OFS_CONFIG_HI, 8'h22);
      want = 6'h09;
      wait_gnt();
      `CHK(g, 6'h01)
      wait_idle();
      wr(OFS_CONFIG_HI, 8'h20);
      want = 6'h09;
      wait_gnt();
      `CHK(g, 6'h08)
      wait_idle();
      int_req = 1'b1;
      tick(4);
      `CHK({int_gnt_n, lan_gnt_n, ext_gnt_n}, 8'h7f)
      int_req = 1'b0;
      wait_idle();
      wr(OFS_MSTS, 8'hff);
      rd(OFS_MSTS, 8'h00);
      {int_req, lan_req, want} = 8'he4;
      tick(3);
      {int_req, lan_req} = 2'b00;
      wait_idle();
      rd(OFS_MSTS, 8'he4);
      wr(OFS_MSTS, 8'h00);
      rd(OFS_MSTS, 8'he4);
      wr(OFS_MSTS, 8'h84);
      rd(OFS_MSTS, 8'h60);
      wr(OFS_ECMD, 8'hff);
      rd(OFS_ECMD, 8'h04);
      system_error_enable = 1'b1;
      pulse(target_abort);
      tick(2);
      `CHK({serr_active, nmi_req, smi_req}, 3'b110)
      rd(OFS_ESTS, 8'h04);
      serr_to_smi = 1'b1;
      tick(2);
      `CHK({serr_active, nmi_req, smi_req}, 3'b101)
      system_error_enable = 1'b0;
      tick(2);
      `CHK(serr_active, 1'b0)
      wr(OFS_ESTS, 8'h04);
      rd(OFS_ESTS, 8'h00);
      wr(OFS_ECMD, 8'h00);
      system_error_enable = 1'b1;
      pulse(target_abort);
      tick(3);
      `CHK(serr_active, 1'b0)
      wr(OFS_CONFIG_HI, 8'h21);
      foreach (hole_addr[i]) begin
         mem_addr = hole_addr[i];
         tick(2);
         `CHK(mem_in_hole, 1'(i == 1 || i == 2))
      end
      wr(OFS_CONFIG_HI, 8'h20);
      mem_addr = 32'h00f00000;
      tick(2);
      `CHK(mem_in_hole, 1'b0)
      wr(OFS_CONFIG_LO, 8'h02);
      pulse(mem_cycle_start);
      for (len = 1; len < 60 && mem_retry !== 1'b1; len++) tick(1);
      if (len == 60) hang();
      `CHK(len >= 34 && len <= 40 && mem_wait === 1'b0, 1'b1)
      wr(OFS_CONFIG_LO, 8'h00);
      pulse(mem_cycle_start);
      seen = 1'b0;
      repeat (60) begin
         tick(1);
         seen = seen | mem_retry;
      end
      `CHK({seen, mem_wait}, 2'b01)
      pulse(mem_cycle_done);
      tick(1);
      `CHK(mem_wait, 1'b0)
      dt_data_ready = 1'b1;
      pulse(dt_start);
      tick(2);
      `CHK(dt_deliver, 1'b0)
      pulse(cpu_write);
      tick(2);
      `CHK(dt_deliver, 1'b1)
      pulse(dt_start);
      tick(2);
      `CHK(dt_deliver, 1'b0)
      wr(OFS_CONFIG_HI, 8'h00);
      pulse(dt_start);
      tick(2);
      `CHK(dt_deliver, 1'b1)
      stop_test();
   end
endmodule
